// ===== rtl/mdt_pkg.sv
// Constants and types for the digital port and totalizer block.
// Assumes one 40 MHz clock and a synchronous active-low reset.
// ======================================================================
// How it works
// - Two 8-bit ports; channel 01 is low byte, 02 high byte.
// - Both ports in one scan are sampled together with one stamp.
// - Direct pattern read gives one port byte or both as a word.
// - Measure replaces list, sweeps once, answers to output buffer only.
// - Configure replaces list and leaves scanning idle until initiated.
// - One event counter per slot, addressed as channel 03.
// - Plain mode keeps count on scan; read-then-clear zeroes after capture.
// - Defaults give plain-read mode with clear on scan off.
// - Count rising edges by default, falling edges when negative chosen.
// - Clear request zeroes the counter at once, without a scan.
// - In read-then-clear mode a direct count read zeroes the counter.
// - Counter is 26 bits and wraps to zero past its maximum.
// - Writing a port as output is refused while it is scanned.
// - Word write goes to port 01 and drives both bytes together.
// - Output readback returns the last byte or word written.
// - Direction query gives 0 for input and 1 for output.
package mdt_pkg;

    // ==================================================================
    // Widths
    localparam int PORT_W = 8;
    localparam int WORD_W = 16;
    localparam int CNT_W = 26;
    localparam int STAMP_W = 16;
    localparam int PAD_W = CNT_W - WORD_W;

    // ==================================================================
    // Channel indices, scan list bit positions and the counter-only list
    localparam logic [1:0] CH_LO = 2'h1;
    localparam logic [1:0] CH_HI = 2'h2;
    localparam logic [1:0] CH_TOT = 2'h3;
    localparam int LIST_LO = 0;
    localparam int LIST_HI = 1;
    localparam int LIST_TOT = 2;
    localparam logic [2:0] LIST_ONLY_TOT = 3'h4;

    // ==================================================================
    // Values after reset, unit steps and counter maximum
    localparam logic [CNT_W-1:0] CNT_RST = 26'h0000000;
    localparam logic [CNT_W-1:0] CNT_ONE = 26'h0000001;
    localparam logic [CNT_W-1:0] CNT_MAX = 26'h3FFFFFF;
    localparam logic [PORT_W-1:0] OUT_RST = 8'h00;
    localparam logic [2:0] LIST_RST = 3'h0;
    localparam logic [1:0] DIR_RST = 2'h0;
    localparam logic MODE_RST = 1'b0;
    localparam logic SLOPE_RST = 1'b0;
    localparam logic [STAMP_W-1:0] STAMP_RST = 16'h0000;
    localparam logic [STAMP_W-1:0] STAMP_ONE = 16'h0001;

    // ==================================================================
    // Commands
    typedef enum logic [3:0] {
        OP_MEAS_DIO, OP_CONF_DIO, OP_MEAS_TOT, OP_CONF_TOT, OP_INIT,
        OP_READ_DIO, OP_READ_TOT, OP_WRITE_OUT, OP_READ_OUT, OP_DIR,
        OP_TOT_CLEAR, OP_SET_TYPE, OP_SET_SLOPE, OP_DEFAULTS
    } mdt_op_t;

endpackage : mdt_pkg

// ===== rtl/mdt_totalizer.sv
// Edge-counting totalizer with selectable edge and immediate clear.
// Assumes totIn is asynchronous; clearNow comes from the same clock.
`timescale 1ns/1ps
module mdt_totalizer import mdt_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Control
    input wire logic totIn,
    input wire logic negSlope,
    input wire logic clearNow,
    // Count
    output logic [CNT_W-1:0] count
);

    // ==================================================================
    // Synchroniser and edge detect
    logic syncA;
    logic syncB;
    logic prevB;
    wire logic rise = syncB && !prevB;
    wire logic fall = !syncB && prevB;
    wire logic step = negSlope ? fall : rise;

    // Two flops then a history flop
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            syncA <= 1'b0;
            syncB <= 1'b0;
            prevB <= 1'b0;
        end else begin
            syncA <= totIn;
            syncB <= syncA;
            prevB <= syncB;
        end
    end

    // ==================================================================
    // Counter; an edge in the clear cycle is kept
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            count <= CNT_RST;
        end else if (clearNow) begin
            count <= step ? CNT_ONE : CNT_RST;
        end else if (step) begin
            count <= count + CNT_ONE;
        end
    end

    // ==================================================================
    // Checks
    property p_wrap;
        @(posedge clk) disable iff (!rst_b)
        (count == CNT_MAX && step && !clearNow) |=> count == CNT_RST;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("counter did not wrap to zero");

    property p_one_per_edge;
        @(posedge clk) disable iff (!rst_b)
        (!clearNow && count != CNT_MAX) |=>
            count == $past(count) + ($past(step) ? CNT_ONE : CNT_RST);
    endproperty
    a_one_per_edge: assert property (p_one_per_edge)
        else $error("count moved by other than one edge");

    property p_edge_sel;
        @(posedge clk) disable iff (!rst_b)
        ($rose(syncB) && negSlope && !clearNow) |=> $stable(count);
    endproperty
    a_edge_sel: assert property (p_edge_sel)
        else $error("rising edge counted in negative mode");

endmodule : mdt_totalizer

// ===== rtl/mdt_dio_totalizer.sv
// Two 8-bit digital ports, scan sequencer and totalizer of one slot.
// Assumes commands come from logic on clk; port pins are asynchronous.
`timescale 1ns/1ps
module mdt_dio_totalizer import mdt_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Command port
    input wire logic cmdValid,
    input wire mdt_op_t cmdOp,
    input wire logic [1:0] cmdChan,
    input wire logic cmdWord,
    input wire logic cmdFlag,
    input wire logic [1:0] cmdPorts,
    input wire logic [WORD_W-1:0] cmdData,
    output logic cmdReady,
    // Answers
    output logic rspValid,
    output logic [CNT_W-1:0] rspData,
    output logic [1:0] rspChan,
    output logic [STAMP_W-1:0] rspStamp,
    output logic rspToMem,
    output logic cmdErr,
    // Status
    output logic [2:0] scanList,
    output logic [1:0] portDir,
    output logic readThenClearMode,
    output logic negSlope,
    // Port pins
    input wire logic [PORT_W-1:0] portIn0,
    input wire logic [PORT_W-1:0] portIn1,
    output logic [PORT_W-1:0] portOut0,
    output logic [PORT_W-1:0] portOut1,
    output logic [PORT_W-1:0] portOe0,
    output logic [PORT_W-1:0] portOe1,
    // Totalizer pin
    input wire logic totIn
);

    typedef enum logic [1:0] {ST_IDLE, ST_LO, ST_HI, ST_TOT} mdt_state_t;

    mdt_state_t state;
    logic [WORD_W-1:0] pinA;
    logic [WORD_W-1:0] pinB;
    logic [PORT_W-1:0] snapLo;
    logic [PORT_W-1:0] snapHi;
    logic [CNT_W-1:0] snapCnt;
    logic [STAMP_W-1:0] stamp;
    logic [STAMP_W-1:0] stampHold;
    logic [2:0] sweepList;
    logic sweepToMem;
    logic [CNT_W-1:0] count;
    logic next_rspValid;
    logic [CNT_W-1:0] next_rspData;
    logic [1:0] next_rspChan;
    logic next_rspToMem;

    // ==================================================================
    // Command decode
    wire logic take = cmdValid && cmdReady;
    wire logic isLo = cmdChan == CH_LO;
    wire logic isHi = cmdChan == CH_HI;
    wire logic isTot = cmdChan == CH_TOT;
    wire logic [1:0] tgt = cmdWord ? 2'h3 : {isHi, isLo};
    wire logic opDio = cmdOp == OP_READ_DIO || cmdOp == OP_WRITE_OUT
        || cmdOp == OP_READ_OUT || cmdOp == OP_DIR;
    wire logic opTot = cmdOp == OP_READ_TOT || cmdOp == OP_TOT_CLEAR
        || cmdOp == OP_SET_TYPE || cmdOp == OP_SET_SLOPE;
    wire logic opListDio = cmdOp == OP_MEAS_DIO || cmdOp == OP_CONF_DIO;
    wire logic opListTot = cmdOp == OP_MEAS_TOT || cmdOp == OP_CONF_TOT;
    wire logic opSweep = cmdOp == OP_MEAS_DIO || cmdOp == OP_MEAS_TOT
        || cmdOp == OP_INIT;
    // Word access only through the low port
    wire logic chanBad = opDio ? (!(isLo || isHi) || (cmdWord && !isLo))
        : (opTot && !isTot);
    // Output refused on a scanned port; word read needs no scanned port
    wire logic scanBad =
        (cmdOp == OP_WRITE_OUT && (tgt & scanList[1:0]) != 2'h0)
        || (cmdOp == OP_READ_DIO && cmdWord
            && scanList[1:0] != 2'h0);
    wire logic cmdBad = chanBad || scanBad;
    wire logic ok = take && !cmdBad;
    wire logic startSweep = ok && opSweep;

    // ==================================================================
    // Next scan list and next counter mode
    wire logic [2:0] nextList = (ok && opListDio) ? {1'b0, cmdPorts}
        : (ok && opListTot) ? LIST_ONLY_TOT : scanList;
    wire logic setMode = ok && (opListTot || cmdOp == OP_SET_TYPE);
    wire logic nextRrc = setMode ? cmdFlag
        : (ok && cmdOp == OP_DEFAULTS) ? MODE_RST
        : readThenClearMode;
    // Clear at once, after a capture, or after a direct read
    wire logic clearNow = (ok && cmdOp == OP_TOT_CLEAR)
        || (ok && cmdOp == OP_READ_TOT && readThenClearMode)
        || (startSweep && nextList[LIST_TOT] && nextRrc);

    // Ports drive while set as outputs
    assign cmdReady = state == ST_IDLE;
    assign portOe0 = {PORT_W{portDir[0]}};
    assign portOe1 = {PORT_W{portDir[1]}};

    // ==================================================================
    // Totalizer
    mdt_totalizer u_tot (
        .clk(clk),
        .rst_b(rst_b),
        .totIn(totIn),
        .negSlope(negSlope),
        .clearNow(clearNow),
        .count(count)
    );

    // Pin synchroniser and free-running time stamp
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pinA <= 16'h0000;
            pinB <= 16'h0000;
            stamp <= STAMP_RST;
        end else begin
            pinA <= {portIn1, portIn0};
            pinB <= pinA;
            stamp <= stamp + STAMP_ONE;
        end
    end

    // ==================================================================
    // Configuration and output latches
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            scanList <= LIST_RST;
            portDir <= DIR_RST;
            readThenClearMode <= MODE_RST;
            negSlope <= SLOPE_RST;
            portOut0 <= OUT_RST;
            portOut1 <= OUT_RST;
        end else begin
            scanList <= nextList;
            readThenClearMode <= nextRrc;
            if (ok && cmdOp == OP_SET_SLOPE) begin
                negSlope <= cmdFlag;
            end else if (ok && cmdOp == OP_DEFAULTS) begin
                negSlope <= SLOPE_RST;
            end
            if (ok && cmdOp == OP_WRITE_OUT) begin
                portDir <= portDir | tgt;
            end else if (ok && opListDio) begin
                portDir <= portDir & ~cmdPorts;
            end
            if (ok && cmdOp == OP_WRITE_OUT && tgt[0]) begin
                portOut0 <= cmdData[7:0];
            end
            if (ok && cmdOp == OP_WRITE_OUT && tgt[1]) begin
                portOut1 <= cmdWord ? cmdData[15:8] : cmdData[7:0];
            end
        end
    end

    // ==================================================================
    // Sweep sequencer: one capture, then one answer slot per channel
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state <= ST_IDLE;
            sweepList <= LIST_RST;
            sweepToMem <= 1'b0;
            snapLo <= OUT_RST;
            snapHi <= OUT_RST;
            snapCnt <= CNT_RST;
            stampHold <= STAMP_RST;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (startSweep) begin
                        state <= ST_LO;
                        sweepList <= nextList;
                        sweepToMem <= cmdOp == OP_INIT;
                        snapLo <= pinB[7:0];
                        snapHi <= pinB[15:8];
                        snapCnt <= count;
                        stampHold <= stamp;
                    end
                end
                ST_LO: begin
                    state <= ST_HI;
                end
                ST_HI: begin
                    state <= ST_TOT;
                end
                ST_TOT: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ==================================================================
    // Answer selection
    always_comb begin
        next_rspValid = 1'b0;
        next_rspData = CNT_RST;
        next_rspChan = cmdChan;
        next_rspToMem = 1'b0;
        unique case (state)
            ST_IDLE: begin
                if (ok && cmdOp == OP_READ_DIO) begin
                    next_rspValid = 1'b1;
                    next_rspData = cmdWord ? {{PAD_W{1'b0}}, pinB}
                        : {{PAD_W{1'b0}}, 8'h00,
                           isLo ? pinB[7:0] : pinB[15:8]};
                end
                if (ok && cmdOp == OP_READ_TOT) begin
                    next_rspValid = 1'b1;
                    next_rspData = count;
                end
                if (ok && cmdOp == OP_READ_OUT) begin
                    next_rspValid = 1'b1;
                    next_rspData = cmdWord
                        ? {{PAD_W{1'b0}}, portOut1, portOut0}
                        : {{PAD_W{1'b0}}, 8'h00,
                           isLo ? portOut0 : portOut1};
                end
                if (ok && cmdOp == OP_DIR) begin
                    next_rspValid = 1'b1;
                    next_rspData = {{(CNT_W-1){1'b0}},
                        isLo ? portDir[0] : portDir[1]};
                end
            end
            ST_LO: begin
                next_rspValid = sweepList[LIST_LO];
                next_rspData = {{PAD_W{1'b0}}, 8'h00, snapLo};
                next_rspChan = CH_LO;
                next_rspToMem = sweepToMem;
            end
            ST_HI: begin
                next_rspValid = sweepList[LIST_HI];
                next_rspData = {{PAD_W{1'b0}}, 8'h00, snapHi};
                next_rspChan = CH_HI;
                next_rspToMem = sweepToMem;
            end
            ST_TOT: begin
                next_rspValid = sweepList[LIST_TOT];
                next_rspData = snapCnt;
                next_rspChan = CH_TOT;
                next_rspToMem = sweepToMem;
            end
        endcase
    end

    // Answer registers
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rspValid <= 1'b0;
            rspData <= CNT_RST;
            rspChan <= 2'h0;
            rspStamp <= STAMP_RST;
            rspToMem <= 1'b0;
            cmdErr <= 1'b0;
        end else begin
            rspValid <= next_rspValid;
            rspData <= next_rspData;
            rspChan <= next_rspChan;
            rspStamp <= (state == ST_IDLE) ? stamp : stampHold;
            rspToMem <= next_rspToMem;
            cmdErr <= take && cmdBad;
        end
    end

    // ==================================================================
    // Checks
    property p_word_write;
        @(posedge clk) disable iff (!rst_b)
        (ok && cmdOp == OP_WRITE_OUT && cmdWord) |=>
            portOut0 == $past(cmdData[7:0])
            && portOut1 == $past(cmdData[15:8]) && portOe0 == 8'hFF
            && portOe1 == 8'hFF;
    endproperty
    a_word_write: assert property (p_word_write)
        else $error("word write did not drive both ports");

    property p_refuse_out;
        @(posedge clk) disable iff (!rst_b)
        (take && cmdOp == OP_WRITE_OUT && (tgt & scanList[1:0]) != 2'h0)
            |=> cmdErr && portDir == $past(portDir);
    endproperty
    a_refuse_out: assert property (p_refuse_out)
        else $error("output accepted on a scanned port");

    property p_clear_now;
        @(posedge clk) disable iff (!rst_b)
        (ok && cmdOp == OP_TOT_CLEAR) |=> count <= CNT_ONE;
    endproperty
    a_clear_now: assert property (p_clear_now)
        else $error("counter not cleared at once");

    property p_defaults;
        @(posedge clk) disable iff (!rst_b)
        (ok && cmdOp == OP_DEFAULTS) |=> !readThenClearMode && !negSlope;
    endproperty
    a_defaults: assert property (p_defaults)
        else $error("defaults left a mode set");

    property p_measure_once;
        @(posedge clk) disable iff (!rst_b)
        (ok && cmdOp == OP_MEAS_DIO) |=> state == ST_LO ##1 state == ST_HI
            ##1 state == ST_TOT ##1 state == ST_IDLE ##0 !rspToMem;
    endproperty
    a_measure_once: assert property (p_measure_once)
        else $error("measure did not sweep exactly once");

    property p_conf_idle;
        @(posedge clk) disable iff (!rst_b)
        (ok && cmdOp == OP_CONF_DIO) |=> state == ST_IDLE && !rspValid
            && scanList == {1'b0, $past(cmdPorts)};
    endproperty
    a_conf_idle: assert property (p_conf_idle)
        else $error("configure started a scan");

    property p_same_stamp;
        @(posedge clk) disable iff (!rst_b)
        (rspValid && rspChan == CH_LO && state == ST_HI
            && sweepList[LIST_HI]) |=>
            rspValid && rspStamp == $past(rspStamp);
    endproperty
    a_same_stamp: assert property (p_same_stamp)
        else $error("port answers of one sweep differ in stamp");

    property p_read_clear;
        @(posedge clk) disable iff (!rst_b)
        (ok && cmdOp == OP_READ_TOT && readThenClearMode) |=>
            rspData == $past(count) && count <= CNT_ONE;
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("read-then-clear left the count");

    c_meas_both: cover property (@(posedge clk) disable iff (!rst_b)
        ok && cmdOp == OP_MEAS_DIO && cmdPorts == 2'h3);
    c_init_tot: cover property (@(posedge clk) disable iff (!rst_b)
        rspValid && rspChan == CH_TOT && rspToMem);
    c_refused: cover property (@(posedge clk) disable iff (!rst_b)
        cmdErr);

endmodule : mdt_dio_totalizer

// ===== verification/mdt_signal_model.sv
// External signal model: port pattern sources and counter pulse source.
// Assumes the bench sets the patterns and the counter level off the edge.
`timescale 1ns/1ps
module mdt_signal_model import mdt_pkg::*; (
    // Bench side
    input wire logic [PORT_W-1:0] srcPat0,
    input wire logic [PORT_W-1:0] srcPat1,
    input wire logic totLvl,
    // Device pins
    input wire logic [PORT_W-1:0] portOut0,
    input wire logic [PORT_W-1:0] portOut1,
    input wire logic [PORT_W-1:0] portOe0,
    input wire logic [PORT_W-1:0] portOe1,
    output logic [PORT_W-1:0] portIn0,
    output logic [PORT_W-1:0] portIn1,
    output logic totIn
);
    // ==================================================================
    // Pin levels: the device wins on every bit that it drives
    assign portIn0 = (portOut0 & portOe0) | (srcPat0 & ~portOe0);
    assign portIn1 = (portOut1 & portOe1) | (srcPat1 & ~portOe1);
    assign totIn = totLvl;
endmodule : mdt_signal_model

// ===== verification/test_multifunction_dio_totalizer.sv
// Self-checking bench for the digital port and totalizer block.
// Assumes the signal model sits on the pins; commands wait for cmdReady.
`timescale 1ns/1ps
module test_multifunction_dio_totalizer import mdt_pkg::*; ;
    logic clk, rst_b, cmdValid, cmdWord, cmdFlag, totLvl, totIn, lastMem;
    mdt_op_t cmdOp;
    logic [1:0] cmdChan, cmdPorts, rspChan, portDir;
    logic [15:0] cmdData;
    logic [7:0] pat0, pat1, portIn0, portIn1;
    logic [7:0] portOut0, portOut1, portOe0, portOe1;
    logic cmdReady, rspValid, rspToMem, cmdErr, readThenClearMode, negSlope;
    logic [CNT_W-1:0] rspData;
    logic [STAMP_W-1:0] rspStamp, lastStamp, s;
    logic [2:0] scanList;
    logic [31:0] seed, r;
    logic [CNT_W-1:0] qData[$];
    logic [1:0] qChan[$];
    logic [STAMP_W-1:0] qStamp[$];
    logic qMem[$];
    int mismatches, nCompared, nErr, e;

    mdt_dio_totalizer DUT (.clk(clk), .rst_b(rst_b), .cmdValid(cmdValid),
        .cmdOp(cmdOp), .cmdChan(cmdChan), .cmdWord(cmdWord),
        .cmdFlag(cmdFlag), .cmdPorts(cmdPorts), .cmdData(cmdData),
        .cmdReady(cmdReady), .rspValid(rspValid), .rspData(rspData),
        .rspChan(rspChan), .rspStamp(rspStamp), .rspToMem(rspToMem),
        .cmdErr(cmdErr), .scanList(scanList), .portDir(portDir),
        .readThenClearMode(readThenClearMode), .negSlope(negSlope),
        .portIn0(portIn0), .portIn1(portIn1), .portOut0(portOut0),
        .portOut1(portOut1), .portOe0(portOe0), .portOe1(portOe1),
        .totIn(totIn));
    mdt_signal_model pins (.srcPat0(pat0), .srcPat1(pat1), .totLvl(totLvl),
        .portOut0(portOut0), .portOut1(portOut1), .portOe0(portOe0),
        .portOe1(portOe1), .portIn0(portIn0), .portIn1(portIn1),
        .totIn(totIn));

    // ==================================================================
    // Clock and answer monitor
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (rspValid === 1'b1) begin
            qData.push_back(rspData);
            qChan.push_back(rspChan);
            qStamp.push_back(rspStamp);
            qMem.push_back(rspToMem);
        end
        if (cmdErr === 1'b1) nErr++;
    end

    // ==================================================================
    // Helpers
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic close_out();
        $display("compared %0d mismatches %0d", nCompared, mismatches);
        if (mismatches == 0 && nCompared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : close_out
    // Hold the request until the edge that takes it, then let it settle
    task automatic cmd(input mdt_op_t op, input logic [1:0] ch,
        input logic w, input logic f, input logic [1:0] pr,
        input logic [15:0] d);
        int n;
        n = 0;
        cmdOp = op;
        cmdChan = ch;
        cmdWord = w;
        cmdFlag = f;
        cmdPorts = pr;
        cmdData = d;
        cmdValid = 1'b1;
        while (cmdReady !== 1'b1 && n < 50) begin
            @(posedge clk);
            #2;
            n++;
        end
        if (n == 50) mismatches++;
        @(posedge clk);
        #2;
        cmdValid = 1'b0;
        if (op == OP_MEAS_DIO) check(32'(cmdReady), 32'h0);
        repeat (6) @(posedge clk);
        #2;
    endtask : cmd
    task automatic pop(input logic [1:0] ch, input logic [31:0] d);
        if (qData.size() == 0) begin
            check(32'hFFFFFFFF, d);
        end else begin
            check(32'(qChan.pop_front()), 32'(ch));
            check(32'(qData.pop_front()), d);
            lastStamp = qStamp.pop_front();
            lastMem = qMem.pop_front();
        end
    endtask : pop
    task automatic newPats();
        r = xs();
        pat0 = r[7:0];
        pat1 = r[15:8];
        repeat (3) @(posedge clk);
        #2;
    endtask : newPats
    task automatic pulse(input int n);
        repeat (n) begin
            totLvl = 1'b1;
            repeat (4) @(posedge clk);
            #2;
            totLvl = 1'b0;
            repeat (4) @(posedge clk);
            #2;
        end
    endtask : pulse

    // ==================================================================
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        close_out();
    end

    // ==================================================================
    // Main sequence
    initial begin
        seed = 32'hAB16;
        {rst_b, cmdValid, cmdWord, cmdFlag, totLvl} = 5'h00;
        {cmdChan, cmdPorts, cmdData, pat0, pat1} = 36'h0;
        cmdOp = OP_DIR;
        repeat (12) @(posedge clk);
        #2;
        rst_b = 1'b1;
        check(32'(readThenClearMode), 32'h0);
        check(32'(negSlope), 32'h0);
        check(32'(portDir), 32'h0);
        // Direct reads of the input ports
        newPats();
        cmd(OP_READ_DIO, 2'h1, 1'b1, 1'b0, 2'h0, 16'h0000);
        pop(2'h1, {16'h0, pat1, pat0});
        cmd(OP_READ_DIO, 2'h2, 1'b0, 1'b0, 2'h0, 16'h0000);
        pop(2'h2, {24'h0, pat1});
        cmd(OP_DIR, 2'h2, 1'b0, 1'b0, 2'h0, 16'h0000);
        pop(2'h2, 32'h0);
        $display("test direct reads done");
        // Random one-shot sweeps of both ports
        for (int i = 0; i < 4; i++) begin
            newPats();
            cmd(OP_MEAS_DIO, 2'h1, 1'b0, 1'b0, 2'h3, 16'h0000);
            pop(2'h1, {24'h0, pat0});
            s = lastStamp;
            check(32'(lastMem), 32'h0);
            pop(2'h2, {24'h0, pat1});
            check(32'(lastStamp), 32'(s));
            check(32'(scanList), 32'h3);
        end
        e = nErr;
        cmd(OP_WRITE_OUT, 2'h1, 1'b0, 1'b0, 2'h0, 16'h005A);
        check(32'(nErr), 32'(e + 1));
        check(32'(portDir), 32'h0);
        cmd(OP_READ_DIO, 2'h1, 1'b1, 1'b0, 2'h0, 16'h0000);
        check(32'(nErr), 32'(e + 2));
        check(32'(qData.size()), 32'h0);
        $display("test sweeps done");
        // Configure without sweep, then initiate
        cmd(OP_CONF_DIO, 2'h1, 1'b0, 1'b0, 2'h1, 16'h0000);
        check(32'(scanList), 32'h1);
        check(32'(qData.size()), 32'h0);
        newPats();
        cmd(OP_INIT, 2'h1, 1'b0, 1'b0, 2'h0, 16'h0000);
        pop(2'h1, {24'h0, pat0});
        check(32'(lastMem), 32'h1);
        cmd(OP_CONF_DIO, 2'h1, 1'b0, 1'b0, 2'h0, 16'h0000);
        $display("test configure done");
        // Output writes and readback
        r = xs();
        cmd(OP_WRITE_OUT, 2'h1, 1'b1, 1'b0, 2'h0, r[15:0]);
        check(32'({portOut1, portOut0}), 32'(r[15:0]));
        check(32'({portOe1, portOe0}), 32'hFFFF);
        cmd(OP_READ_OUT, 2'h1, 1'b1, 1'b0, 2'h0, 16'h0000);
        pop(2'h1, 32'(r[15:0]));
        cmd(OP_WRITE_OUT, 2'h2, 1'b0, 1'b0, 2'h0, 16'h00FF);
        check(32'(portOut1), 32'hFF);
        cmd(OP_READ_OUT, 2'h2, 1'b0, 1'b0, 2'h0, 16'h0000);
        pop(2'h2, 32'hFF);
        cmd(OP_DIR, 2'h2, 1'b0, 1'b0, 2'h0, 16'h0000);
        pop(2'h2, 32'h1);
        $display("test outputs done");
        // Totalizer edges, sweeps, read-then-clear and clear
        cmd(OP_TOT_CLEAR, 2'h3, 1'b0, 1'b0, 2'h0, 16'h0000);
        pulse(5);
        cmd(OP_READ_TOT, 2'h3, 1'b0, 1'b0, 2'h0, 16'h0000);
        pop(2'h3, 32'h5);
        cmd(OP_MEAS_TOT, 2'h3, 1'b0, 1'b0, 2'h0, 16'h0000);
        pop(2'h3, 32'h5);
        check(32'(scanList), 32'h4);
        cmd(OP_MEAS_TOT, 2'h3, 1'b0, 1'b1, 2'h0, 16'h0000);
        pop(2'h3, 32'h5);
        cmd(OP_READ_TOT, 2'h3, 1'b0, 1'b0, 2'h0, 16'h0000);
        pop(2'h3, 32'h0);
        pulse(2);
        cmd(OP_READ_TOT, 2'h3, 1'b0, 1'b0, 2'h0, 16'h0000);
        pop(2'h3, 32'h2);
        cmd(OP_DEFAULTS, 2'h3, 1'b0, 1'b0, 2'h0, 16'h0000);
        check(32'(readThenClearMode), 32'h0);
        pulse(3);
        cmd(OP_TOT_CLEAR, 2'h3, 1'b0, 1'b0, 2'h0, 16'h0000);
        cmd(OP_READ_TOT, 2'h3, 1'b0, 1'b0, 2'h0, 16'h0000);
        pop(2'h3, 32'h0);
        cmd(OP_SET_SLOPE, 2'h3, 1'b0, 1'b1, 2'h0, 16'h0000);
        check(32'(negSlope), 32'h1);
        totLvl = 1'b1;
        repeat (4) @(posedge clk);
        #2;
        cmd(OP_READ_TOT, 2'h3, 1'b0, 1'b0, 2'h0, 16'h0000);
        pop(2'h3, 32'h0);
        totLvl = 1'b0;
        repeat (4) @(posedge clk);
        #2;
        cmd(OP_READ_TOT, 2'h3, 1'b0, 1'b0, 2'h0, 16'h0000);
        pop(2'h3, 32'h1);
        e = nErr;
        cmd(OP_READ_TOT, 2'h1, 1'b0, 1'b0, 2'h0, 16'h0000);
        check(32'(nErr), 32'(e + 1));
        $display("test totalizer done");
        close_out();
    end
endmodule : test_multifunction_dio_totalizer
